// ===== hdl/acc_conversion_control.sv
// Purpose: control logic of a 10-bit successive-approximation converter
// Assumes: sys_clk 10 MHz, synchronous active-high reset, wishbone classic
// Notes: the analog comparator is outside; compHigh answers the trial value
`timescale 1ns/1ps
// Behaviour
// [R1] each sample resolved by successive approximation, up to 10 bits
// [R2] result unsigned, right-justified, 10 or 8 bits per resolution
// [R3] single or continuous; single returns to idle by itself
// [R4] compare enabled: flag only on less-than or greater-or-equal per sense
// [R5] two-bit field at bits 1:0 picks input clock; 00 is bus clock
// [R6] configuration bit 7 picks low power, lower converter clock
// [R7] bits 6:5 divide input clock to converter clock; 00 divides by one
// [R8] configuration bit 4 picks the long sample time
// [R9] bits 3:2 pick resolution; code 10 gives 10-bit conversions
// [R10] trigger/compare bit 7 shows conversion in progress
// [R11] trigger/compare bit 6: zero software, one hardware trigger input
// [R12] trigger/compare bit 5 enables compare using compare value pair
// [R13] trigger/compare bits 3:2 read zero; software writes zero to 1:0
// [R14] channel/mode bit 7 is read-only completion flag
// [R15] channel/mode bit 6 enables completion interrupt request
// [R16] channel/mode bit 5 selects continuous conversions; code resamples only under software trigger
// [R17] channel/mode bits 4:0 select channel; 00001 is channel 1
// [R18] high byte read first; low byte held until read
// [R19] pin-control bit set frees matching analog pin from port logic
// [R20] conversions keep running in wait and stop3 modes
// [R21] software sets trigger/compare before writing channel/mode
// [R22] channel select addresses up to 28 inputs
// [R23] software trigger: channel/mode write aborts and restarts conversion
module acc_conversion_control (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock sources and trigger
  input wire logic [3:0] clockSources,
  input wire logic hwTrigger,
  // analog front end
  input wire logic compHigh,
  output logic [4:0] channelSelect,
  output logic [9:0] trialValue,
  output logic sampleActive,
  output logic lowPowerSelect,
  // pin control and interrupt
  output logic [23:0] pinDisable,
  output logic completeIrq
);
  // registers
  logic [7:0] config_r;
  logic [7:0] trigCmp_r;
  logic [7:0] chanMode_r;
  logic [9:0] result_r;
  logic [9:0] compare_r;
  logic [23:0] pinCtl_r;
  logic lowHeld_r;
  logic [1:0] lowByte_r;
  acc_pkg::acc_state_t state_r;
  logic [4:0] sampleCnt_r;
  logic [3:0] bitIdx_r;
  logic [9:0] sar_r;
  logic [2:0] divCnt_r;
  logic [3:0] clkSync1_r;
  logic [3:0] clkSync2_r;
  logic clkPrev_r;
  logic trigSync1_r;
  logic trigSync2_r;
  logic trigPrev_r;
  logic ack_r;
  logic [31:0] rdata_r;

  logic access;
  logic wrStb;
  logic rdStb;
  logic chanWrite;
  logic tick;
  logic srcLevel;
  logic srcEdge;
  logic trigEdge;
  logic startReq;
  logic lastBit;
  logic [9:0] finalVal;
  logic [9:0] resultVal;
  logic [4:0] startChan;
  logic cmpPass;
  logic [2:0] divLimit;

  // byte-lane write helper, data lives in lane zero
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction : lane0

  // lowest bit under trial; an 8-bit conversion resolves only the top
  // eight bits, so the comparator always sees full-scale trial codes
  function automatic logic [3:0] low_bit(input logic [1:0] res);
    low_bit = (res == acc_pkg::RES_10BIT) ? 4'h0 : 4'h2;
  endfunction : low_bit

  // one-hot weight of a trial bit
  function automatic logic [9:0] trial_bit(input logic [3:0] idx);
    trial_bit = 10'h001 << idx;
  endfunction : trial_bit

  // a request is taken once; ack_r masks the second cycle of the request
  assign access = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrStb = access & wb_we_i;
  assign rdStb = access & ~wb_we_i;
  assign chanWrite = wrStb & (wb_adr_i == acc_pkg::OFS_CHANMODE) &
                     wb_sel_i[0];
  // the channel a start will use; a write is checked on its own data,
  // since the register still holds the old code at the taking edge
  assign startChan = chanWrite ? wb_dat_i[4:0] : chanMode_r[4:0];

  // input clock select; 00 is bus clock, others sampled pins
  assign srcLevel = clkSync2_r[config_r[1:0]]; // R5
  assign srcEdge = srcLevel & ~clkPrev_r;
  // divider 1,2,4,8; low power adds one held enable period per tick
  assign divLimit = (3'h1 << config_r[6:5]) - 3'h1; // R7
  // the low-power hold period is an enable that yields no tick
  assign tick = (config_r[1:0] == acc_pkg::CLKSEL_BUS | srcEdge) &
                ~lowHeld_r & (divCnt_r == divLimit); // R6

  assign trigEdge = trigSync2_r & ~trigPrev_r;
  // hardware trigger edge or software write starts a conversion
  assign startReq = trigCmp_r[acc_pkg::TC_TRIGGER] ? trigEdge :
                    chanWrite; // R11 R23
  assign lastBit = (bitIdx_r == low_bit(config_r[3:2])); // R9
  // keep the trial bit when the input is at or above the trial code
  assign finalVal = compHigh ? (sar_r | trial_bit(bitIdx_r)) : sar_r; // R1
  // 8-bit results are shifted down to sit right-justified
  assign resultVal = (config_r[3:2] == acc_pkg::RES_10BIT) ? finalVal :
                     {2'b00, finalVal[9:2]}; // R2
  // compare sense: greater-or-equal when set, else less-than; the compare
  // works on the formatted result, so 8-bit values need 8-bit limits
  assign cmpPass = ~trigCmp_r[acc_pkg::TC_CMP_EN] |
                   (trigCmp_r[acc_pkg::TC_CMP_GT] ?
                    (resultVal >= compare_r) :
                    (resultVal < compare_r)); // R4 R12

  // pin synchronisers for clock sources and trigger; edges are taken
  // after the second flop only, never from the first
  always_ff @(posedge sys_clk) begin
    clkSync1_r <= clockSources;
    clkSync2_r <= clkSync1_r;
    trigSync1_r <= hwTrigger;
    trigSync2_r <= trigSync1_r;
    clkPrev_r <= srcLevel;
    trigPrev_r <= trigSync2_r;
  end

  // converter clock divider; low power holds one extra enable after each tick
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCnt_r <= 3'h0;
      lowHeld_r <= 1'b0;
    end else if (config_r[1:0] == acc_pkg::CLKSEL_BUS | srcEdge) begin
      if (lowHeld_r) begin
        lowHeld_r <= 1'b0;
      end else if (divCnt_r == divLimit) begin
        divCnt_r <= 3'h0;
        lowHeld_r <= config_r[acc_pkg::CFG_LOW_POWER]; // R6
      end else begin
        divCnt_r <= divCnt_r + 3'h1;
      end
    end
  end

  // configuration, trigger/compare, compare value and pin registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_r <= acc_pkg::CONFIG_RST;
      trigCmp_r <= acc_pkg::TRIGCMP_RST;
      compare_r <= 10'h000;
      pinCtl_r <= 24'h00_0000;
    end else if (wrStb) begin
      unique case (wb_adr_i)
        acc_pkg::OFS_CONFIG:
          config_r <= lane0(config_r, wb_dat_i, wb_sel_i); // R5 R6 R7 R8 R9
        // busy flag and reserved bits are never stored
        acc_pkg::OFS_TRIGCMP:
          if (wb_sel_i[0]) trigCmp_r <= {1'b0, wb_dat_i[6:4], 4'h0}; // R13
        acc_pkg::OFS_CMP_HI:
          if (wb_sel_i[0]) compare_r[9:8] <= wb_dat_i[1:0];
        acc_pkg::OFS_CMP_LO:
          if (wb_sel_i[0]) compare_r[7:0] <= wb_dat_i[7:0];
        acc_pkg::OFS_PIN_ONE:
          pinCtl_r[7:0] <= lane0(pinCtl_r[7:0], wb_dat_i, wb_sel_i); // R19
        acc_pkg::OFS_PIN_TWO:
          pinCtl_r[15:8] <= lane0(pinCtl_r[15:8], wb_dat_i, wb_sel_i);
        acc_pkg::OFS_PIN_THREE:
          pinCtl_r[23:16] <= lane0(pinCtl_r[23:16], wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // channel/mode register; completion set wins over a clearing result read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chanMode_r <= acc_pkg::CHANMODE_RST;
    end else begin
      if (chanWrite) begin
        chanMode_r[6:0] <= wb_dat_i[6:0]; // R15 R16 R17 R22
        chanMode_r[acc_pkg::CM_DONE] <= 1'b0;
      end
      if (rdStb & wb_adr_i == acc_pkg::OFS_RESULT_LO) begin
        chanMode_r[acc_pkg::CM_DONE] <= 1'b0;
      end
      // an abort by a channel write must not leave a stale completion
      if (state_r == acc_pkg::ST_CONVERT & tick & lastBit & cmpPass &
          ~chanWrite) begin
        chanMode_r[acc_pkg::CM_DONE] <= 1'b1; // R14
      end
    end
  end

  // sequencer: sample, then one trial bit per converter clock; the trial
  // code is registered so that it always matches sar_r and bitIdx_r
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= acc_pkg::ST_IDLE;
      sampleCnt_r <= 5'h00;
      bitIdx_r <= 4'h0;
      sar_r <= 10'h000;
      trialValue <= 10'h000;
    end else if (startReq & startChan < acc_pkg::CHANNEL_COUNT) begin
      state_r <= acc_pkg::ST_SAMPLE; // R23
      sampleCnt_r <= config_r[acc_pkg::CFG_LONG_SAMPLE] ?
                     acc_pkg::SAMPLE_LONG : acc_pkg::SAMPLE_SHORT; // R8
      sar_r <= 10'h000;
      trialValue <= 10'h000;
    end else if (chanWrite) begin
      state_r <= acc_pkg::ST_IDLE; // disabled channel code, or a write under hardware trigger with no trigger edge that cycle, stops
      trialValue <= 10'h000;
    end else if (tick) begin
      unique case (state_r)
        acc_pkg::ST_IDLE: ;
        acc_pkg::ST_SAMPLE:
          if (sampleCnt_r == 5'h00) begin
            // every conversion starts from zero at the full-scale top bit
            state_r <= acc_pkg::ST_CONVERT;
            bitIdx_r <= 4'h9;
            sar_r <= 10'h000;
            trialValue <= trial_bit(4'h9); // R1
          end else begin
            sampleCnt_r <= sampleCnt_r - 5'h01;
          end
        acc_pkg::ST_CONVERT: begin
          sar_r <= finalVal; // R1
          bitIdx_r <= bitIdx_r - 4'h1;
          if (lastBit) begin
            trialValue <= 10'h000;
            // R3 R16: single returns idle, continuous resamples only under software trigger
            if (chanMode_r[acc_pkg::CM_CONT] &
                ~trigCmp_r[acc_pkg::TC_TRIGGER]) begin
              state_r <= acc_pkg::ST_SAMPLE;
              sampleCnt_r <= config_r[acc_pkg::CFG_LONG_SAMPLE] ?
                             acc_pkg::SAMPLE_LONG : acc_pkg::SAMPLE_SHORT;
            end else begin
              state_r <= acc_pkg::ST_IDLE;
            end
          end else begin
            trialValue <= finalVal | trial_bit(bitIdx_r - 4'h1);
          end
        end
        default: state_r <= acc_pkg::ST_IDLE;
      endcase
    end
  end

  // result latch; frozen between a high-byte read and the low-byte read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      result_r <= 10'h000;
      lowByte_r <= 2'h0;
    end else begin
      if (rdStb & wb_adr_i == acc_pkg::OFS_RESULT_HI) begin
        lowByte_r <= 2'h1; // R18
      end else if (rdStb & wb_adr_i == acc_pkg::OFS_RESULT_LO) begin
        lowByte_r <= 2'h0;
      end
      // a completion during the freeze is flagged but its value dropped
      if (state_r == acc_pkg::ST_CONVERT & tick & lastBit & cmpPass &
          lowByte_r == 2'h0) begin
        result_r <= resultVal; // R2 R4 R18
      end
    end
  end

  // wishbone answer: one-cycle ack, read data registered with it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= access;
      if (rdStb) begin
        unique case (wb_adr_i)
          acc_pkg::OFS_CONFIG: rdata_r <= {24'h00_0000, config_r};
          acc_pkg::OFS_TRIGCMP:
            rdata_r <= {24'h00_0000, state_r != acc_pkg::ST_IDLE,
                        trigCmp_r[6:4], 4'h0}; // R10 R13
          acc_pkg::OFS_CHANMODE: rdata_r <= {24'h00_0000, chanMode_r};
          acc_pkg::OFS_RESULT_HI: rdata_r <= {30'h0000_0000, result_r[9:8]};
          acc_pkg::OFS_RESULT_LO: rdata_r <= {24'h00_0000, result_r[7:0]};
          acc_pkg::OFS_CMP_HI: rdata_r <= {30'h0000_0000, compare_r[9:8]};
          acc_pkg::OFS_CMP_LO: rdata_r <= {24'h00_0000, compare_r[7:0]};
          acc_pkg::OFS_PIN_ONE: rdata_r <= {24'h00_0000, pinCtl_r[7:0]};
          acc_pkg::OFS_PIN_TWO: rdata_r <= {24'h00_0000, pinCtl_r[15:8]};
          acc_pkg::OFS_PIN_THREE: rdata_r <= {24'h00_0000, pinCtl_r[23:16]};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // front-end outputs, all registered; nothing gates on wait or stop
  // modes, so conversions carry on there; the trial code is sequencer's
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      channelSelect <= 5'h1F;
      sampleActive <= 1'b0;
      lowPowerSelect <= 1'b0;
      pinDisable <= 24'h00_0000;
      completeIrq <= 1'b0;
    end else begin
      channelSelect <= chanMode_r[4:0]; // R17
      sampleActive <= (state_r == acc_pkg::ST_SAMPLE); // R20
      lowPowerSelect <= config_r[acc_pkg::CFG_LOW_POWER];
      pinDisable <= pinCtl_r; // R19
      completeIrq <= chanMode_r[acc_pkg::CM_DONE] &
                     chanMode_r[acc_pkg::CM_IRQ_EN]; // R15
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
endmodule : acc_conversion_control

// ===== hdl/acc_pkg.sv
// Purpose: constants for the converter control block
// Assumes: classic wishbone slave, 32-bit data, byte registers in low bits
// Notes: register offsets are byte addresses of aligned words
package acc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_TRIGCMP = 8'h04;
  localparam logic [7:0] OFS_CHANMODE = 8'h08;
  localparam logic [7:0] OFS_RESULT_HI = 8'h0C;
  localparam logic [7:0] OFS_RESULT_LO = 8'h10;
  localparam logic [7:0] OFS_CMP_HI = 8'h14;
  localparam logic [7:0] OFS_CMP_LO = 8'h18;
  localparam logic [7:0] OFS_PIN_ONE = 8'h1C;
  localparam logic [7:0] OFS_PIN_TWO = 8'h20;
  localparam logic [7:0] OFS_PIN_THREE = 8'h24;
  // configuration fields
  localparam int CFG_LOW_POWER = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_RES_LSB = 2;
  localparam int CFG_CLKSEL_LSB = 0;
  // trigger/compare fields
  localparam int TC_ACTIVE = 7;
  localparam int TC_TRIGGER = 6;
  localparam int TC_CMP_EN = 5;
  localparam int TC_CMP_GT = 4;
  // channel/mode fields
  localparam int CM_DONE = 7;
  localparam int CM_IRQ_EN = 6;
  localparam int CM_CONT = 5;
  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] TRIGCMP_RST = 8'h00;
  localparam logic [7:0] CHANMODE_RST = 8'h1F;
  // resolution codes
  localparam logic [1:0] RES_8BIT = 2'h0;
  localparam logic [1:0] RES_10BIT = 2'h2;
  // sample counts in converter clock periods, channel count and bus clock code
  localparam logic [4:0] SAMPLE_SHORT = 5'h03;
  localparam logic [4:0] SAMPLE_LONG = 5'h13;
  localparam logic [4:0] CHANNEL_COUNT = 5'h1C;
  localparam logic [1:0] CLKSEL_BUS = 2'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } acc_state_t;
endpackage : acc_pkg

// ===== tb/acc_conversion_control_props.sv
// Purpose: port-level assertions for the converter control block
// Assumes: one request per ack, answer one cycle after the taking edge
// Notes: bound to every instance of the design top
`timescale 1ns/1ps
module acc_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // converter side
  input wire logic [4:0] channelSelect,
  input wire logic sampleActive,
  input wire logic lowPowerSelect,
  input wire logic [23:0] pinDisable,
  input wire logic completeIrq
);
  logic rdAck;
  logic wrAck;
  // an answered read or write, with the request still held
  assign rdAck = wb_ack_o && !wb_we_i;
  assign wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_no_stray_ack: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_reset_outputs: assert property (
    $fell(reset) |-> channelSelect == 5'h1F &&
    pinDisable == 24'h00_0000 && !completeIrq)
    else $error("outputs not at reset values");
  a_reserved_zero: assert property (
    rdAck && wb_adr_i == acc_pkg::OFS_TRIGCMP |-> wb_dat_o[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
  a_active_flag: assert property (
    rdAck && wb_adr_i == acc_pkg::OFS_TRIGCMP && sampleActive &&
    $past(sampleActive) && $past(sampleActive, 2) |-> wb_dat_o[7])
    else $error("active flag low while sampling");
  a_unmapped_zero: assert property (
    rdAck && wb_adr_i > acc_pkg::OFS_PIN_THREE |->
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_low_power: assert property (
    wrAck && wb_adr_i == acc_pkg::OFS_CONFIG && wb_dat_i[7] |->
    ##[1:2] lowPowerSelect)
    else $error("low power not selected");
  a_pin_write: assert property (
    wrAck && wb_adr_i == acc_pkg::OFS_PIN_ONE |=>
    pinDisable[7:0] == $past(wb_dat_i[7:0]))
    else $error("pin control not updated");
  a_chan_write: assert property (
    wrAck && wb_adr_i == acc_pkg::OFS_CHANMODE |=>
    channelSelect == $past(wb_dat_i[4:0]))
    else $error("channel not updated");
  a_irq_off: assert property (
    wrAck && wb_adr_i == acc_pkg::OFS_CHANMODE && !wb_dat_i[6] |=>
    !completeIrq)
    else $error("irq high with enable clear");
endmodule : acc_props
bind acc_conversion_control acc_props u_props (
  .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .channelSelect(channelSelect),
  .sampleActive(sampleActive), .lowPowerSelect(lowPowerSelect),
  .pinDisable(pinDisable), .completeIrq(completeIrq));

// ===== tb/acc_analog_model.sv
// Purpose: analog multiplexer and comparator seen by the converter
// Assumes: comparator settles within the same bus cycle
// Notes: only two inputs carry a level, the rest sit at ground
`timescale 1ns/1ps
module acc_analog_model #(
  parameter logic [9:0] LEVEL_ONE = 10'h2A5,
  parameter logic [9:0] LEVEL_LAST = 10'h15A
) (
  // converter side
  input wire logic [4:0] channelSelect,
  input wire logic [9:0] trialValue,
  // comparator answer
  output logic compHigh
);
  logic [9:0] level;
  // codes of 28 and above select nothing and read as ground
  always_comb begin
    case (channelSelect)
      5'h01: level = LEVEL_ONE;
      5'h1B: level = LEVEL_LAST;
      default: level = 10'h000;
    endcase
  end
  assign compHigh = (level >= trialValue);
endmodule : acc_analog_model

// ===== tb/tb_acc_conversion_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: analog model answers the comparator
// Notes: expected codes come from the model levels, never from the design
`timescale 1ns/1ps
module tb_acc_conversion_control;
  logic sysClk, reset, cyc, stb, we, hwTrig, ack, compHigh;
  logic sampleAct, lowPwr, irq;
  logic [7:0] adr, rd;
  logic [3:0] sel, clkSrc;
  logic [31:0] datI, datO;
  logic [4:0] chan;
  logic [9:0] trial;
  logic [23:0] pins;
  logic [7:0] cfgs [6] = '{8'h08, 8'h29, 8'h4B, 8'h62, 8'h98, 8'hF8};
  int miscompares = 0;
  int nCompared = 0;
  int cycles = 0;
  acc_conversion_control dut (
    .sys_clk(sysClk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .clockSources(clkSrc),
    .hwTrigger(hwTrig), .compHigh(compHigh), .channelSelect(chan),
    .trialValue(trial), .sampleActive(sampleAct), .lowPowerSelect(lowPwr),
    .pinDisable(pins), .completeIrq(irq));
  acc_analog_model model (
    .channelSelect(chan), .trialValue(trial), .compHigh(compHigh));
  // clock source pins toggle at fractions of the bus clock; hang guard
  always @(posedge sysClk) begin
    clkSrc <= clkSrc + 4'h1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    sysClk = 1'b0;
    forever #50 sysClk = ~sysClk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; read data lands in rd at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= {24'h00_0000, d};
    do @(posedge sysClk); while (ack !== 1'b1);
    rd = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wait_done;
    rd = 8'h00;
    while (rd[7] !== 1'b1) wb(1'b0, acc_pkg::OFS_CHANMODE, 8'h00);
  endtask : wait_done
  // high byte first so the pair cannot be split by the next result
  task automatic result(input logic [9:0] exp);
    wb(1'b0, acc_pkg::OFS_RESULT_HI, 8'h00);
    check(32'(rd), 32'(exp[9:8]));
    wb(1'b0, acc_pkg::OFS_RESULT_LO, 8'h00);
    check(32'(rd), 32'(exp[7:0]));
  endtask : result
  task automatic convert(input logic [7:0] mode, input logic [9:0] exp);
    wb(1'b1, acc_pkg::OFS_CHANMODE, mode);
    wait_done();
    check(32'(irq), 32'(mode[6]));
    result(exp);
  endtask : convert
  task automatic close_out;
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    reset = 1'b1;
    {cyc, stb, we, hwTrig} = 4'h0;
    adr = 8'h00;
    sel = 4'h1;
    datI = 32'h0000_0000;
    clkSrc = 4'h0;
    repeat (16) @(posedge sysClk);
    reset <= 1'b0;
    wb(1'b0, acc_pkg::OFS_CONFIG, 8'h00);
    check(32'(rd), 32'(acc_pkg::CONFIG_RST));
    wb(1'b0, acc_pkg::OFS_CHANMODE, 8'h00);
    check(32'(rd), 32'(acc_pkg::CHANMODE_RST));
    wb(1'b0, 8'h28, 8'h00);
    check(32'(rd), 32'h0000_0000);
    wb(1'b1, acc_pkg::OFS_TRIGCMP, 8'h0C);
    wb(1'b0, acc_pkg::OFS_TRIGCMP, 8'h00);
    check(32'(rd), 32'h0000_0000);
    wb(1'b1, acc_pkg::OFS_PIN_ONE, 8'h02);
    @(posedge sysClk); // the pin output is registered one edge later
    check(32'(pins), 32'h0000_0002);
    // every divider, source, sample time and resolution at least once
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, acc_pkg::OFS_CONFIG, cfgs[i]);
      wb(1'b0, acc_pkg::OFS_CONFIG, 8'h00);
      check(32'(rd), 32'(cfgs[i]));
      check(32'(lowPwr), 32'(cfgs[i][7]));
      convert(8'h41, (cfgs[i][3:2] == acc_pkg::RES_10BIT) ?
              10'h2A5 : 10'h0A9);
      wb(1'b0, acc_pkg::OFS_TRIGCMP, 8'h00);
      check(32'(rd[7]), 32'h0000_0000);
    end
    convert(8'h21, 10'h2A5);
    wait_done();
    result(10'h2A5);
    // continuous mode under software trigger never rests, so the busy flag must read set
    wb(1'b0, acc_pkg::OFS_TRIGCMP, 8'h00);
    check(32'(rd[7]), 32'h0000_0001);
    convert(8'h1B, 10'h15A);
    wb(1'b1, acc_pkg::OFS_CMP_HI, 8'h01);
    wb(1'b1, acc_pkg::OFS_CMP_LO, 8'h00);
    wb(1'b1, acc_pkg::OFS_TRIGCMP, 8'h30);
    convert(8'h01, 10'h2A5);
    wb(1'b1, acc_pkg::OFS_TRIGCMP, 8'h20);
    wb(1'b1, acc_pkg::OFS_CHANMODE, 8'h01);
    repeat (1000) @(posedge sysClk);
    wb(1'b0, acc_pkg::OFS_CHANMODE, 8'h00);
    check(32'(rd[7]), 32'h0000_0000);
    wb(1'b1, acc_pkg::OFS_CMP_HI, 8'h03);
    convert(8'h01, 10'h2A5);
    wb(1'b1, acc_pkg::OFS_TRIGCMP, 8'h40);
    wb(1'b1, acc_pkg::OFS_CHANMODE, 8'h01);
    repeat (20) @(posedge sysClk);
    wb(1'b0, acc_pkg::OFS_TRIGCMP, 8'h00);
    check(32'(rd[7]), 32'h0000_0000);
    hwTrig <= 1'b1;
    repeat (4) @(posedge sysClk);
    hwTrig <= 1'b0;
    wait_done();
    result(10'h2A5);
    close_out();
  end
endmodule : tb_acc_conversion_control
